// ===== peb_pkg.sv
// Constants and types shared by the port and external bus pin logic
// Function
// - Program store strobe pulses low for code fetches, otherwise held high.
// - Address latch strobe high 1.5 oscillator cycles, period four oscillator cycles.
// - Address latch strobe forced high during reset.
// - Strobe disable set holds address latch strobe high.
// - External accesses pulse the address latch strobe regardless of the disable.
// - Address latch strobe marks the low address byte on port 0.
// - Port 0 shows address while strobe high, then becomes the data bus.
// - Port 0 is open-drain I/O; bus mode drives high levels actively.
// - Port 0 pins float after reset.
// - Port 1 latches reset to one, pins held by weak pull-up.
// - Weakly pulled port 1 pin also reads as an input.
// - Writing zero to port 1 bit enables strong pull-down until one or reset.
// - Port 1 zero-to-one change briefly drives strong high, then weak pull-up.
// - Port 1 bit 0 is timer 2 pin, bit 1 its trigger input.
// - Port 1 bit 2 is serial 1 receive, bit 3 serial 1 transmit.
// - Port 1 bits 4..7 are interrupts; 4,6 rising edge, 5,7 falling edge.
// - Oscillator cycles form the time base for strobe timing.
package peb_pkg;

   // Clock runs at twice the oscillator rate so half oscillator cycles exist
   localparam int CLK_PERIOD_NS   = 25;
   localparam int OSC_PERIOD_NS   = 50;
   localparam int STROBE_HIGH_NS  = OSC_PERIOD_NS * 3 / 2;
   localparam int MC_PERIOD_NS    = OSC_PERIOD_NS * 4;
   localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MC_CYC          = MC_PERIOD_NS / CLK_PERIOD_NS;
   localparam int KICK_NS         = 50;
   localparam int KICK_CYC        = (KICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam logic [2:0] PH_LAST        = 3'(MC_CYC - 1);
   localparam logic [2:0] PH_STROBE_FALL = 3'(STROBE_HIGH_CYC);
   localparam logic [2:0] PH_PROGRAM_STORE_STROBE_N_FIRST  = 3'h4;
   localparam logic [2:0] PH_PROGRAM_STORE_STROBE_N_LAST   = 3'h6;
   localparam logic [1:0] KICK_LOAD      = 2'(KICK_CYC);

   localparam logic [7:0] P0_LATCH_RST = 8'hff;
   localparam logic [7:0] P1_LATCH_RST = 8'hff;

   localparam int BIT_TIMER2_PIN  = 0;
   localparam int BIT_TIMER2_TRIG = 1;
   localparam int BIT_SER1_RX     = 2;
   localparam int BIT_SER1_TX     = 3;
   localparam int BIT_IRQ_RISE_A  = 4;
   localparam int BIT_IRQ_FALL_A  = 5;
   localparam int BIT_IRQ_RISE_B  = 6;
   localparam int BIT_IRQ_FALL_B  = 7;

   typedef enum logic [1:0] {
      XK_IDLE  = 2'b00,
      XK_CODE  = 2'b01,
      XK_READ  = 2'b10,
      XK_WRITE = 2'b11
   } peb_xkind_t;

   typedef struct packed {
      peb_xkind_t kind;
      logic [7:0] addr_lo;
      logic [7:0] wdata;
   } peb_xreq_t;

endpackage : peb_pkg

// ===== peb_p1_bit.sv
// One quasi-bidirectional port 1 pin with sync and edge detect
`timescale 1ns/1ps
module peb_p1_bit
   import peb_pkg::*;
(
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic wr,
   input  wire logic wdata,
   input  wire logic alt_drive,
   input  wire logic pin_i,
   output logic      pin_o,
   output logic      pin_oe,
   output logic      weak_pu,
   output logic      pin_level,
   output logic      rise,
   output logic      fall
);

   logic       latch;
   logic       eff;
   logic       eff_q;
   logic [1:0] kick;
   logic       s1;
   logic       s3;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         latch <= 1'b1;
      end else if (wr) begin
         latch <= wdata;
      end
   end

   // Alternate output only ever pulls low, like a written zero
   assign eff = latch & alt_drive;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         eff_q <= 1'b1;
         kick  <= 2'h0;
      end else begin
         eff_q <= eff;
         if (eff && !eff_q) begin
            kick <= KICK_LOAD;
         end else if (kick != 2'h0) begin
            kick <= kick - 2'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_o   <= 1'b0;
         pin_oe  <= 1'b0;
         weak_pu <= 1'b1;
      end else if (!eff) begin
         pin_o   <= 1'b0;
         pin_oe  <= 1'b1;
         weak_pu <= 1'b0;
      end else if (!eff_q || kick > 2'h1) begin
         pin_o   <= 1'b1;
         pin_oe  <= 1'b1;
         weak_pu <= 1'b0;
      end else begin
         pin_o   <= 1'b0;
         pin_oe  <= 1'b0;
         weak_pu <= 1'b1;
      end
   end

   // First stage read only by the second
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1        <= 1'b1;
         pin_level <= 1'b1;
         s3        <= 1'b1;
         rise      <= 1'b0;
         fall      <= 1'b0;
      end else begin
         s1        <= pin_i;
         pin_level <= s1;
         s3        <= pin_level;
         rise      <= pin_level && !s3;
         fall      <= !pin_level && s3;
      end
   end

   default clocking dcb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_p1_pull_down: assert property (!eff |=> pin_oe && !pin_o)
      else $error("port 1 zero not driven low");
   a_p1_kick_high: assert property ($rose(eff) |=> pin_oe && pin_o)
      else $error("port 1 rise missed strong high");
   a_p1_kick_ends: assert property (eff [*5] |-> !pin_oe && weak_pu)
      else $error("port 1 strong high lasted too long");
   a_p1_edge_det: assert property (rise |-> $past(pin_level) && !$past(s3))
      else $error("port 1 rise pulse without edge");

endmodule : peb_p1_bit

// ===== peb_pins.sv
// Port 0, port 1 and external memory strobe pin logic
`timescale 1ns/1ps
module peb_pins
   import peb_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       latch_strobe_disable,
   input  wire peb_xreq_t  xreq,
   output logic            xreq_slot,
   output logic            xdone,
   output logic [7:0]      xrdata,
   input  wire logic       p0_wr,
   input  wire logic [7:0] p0_wdata,
   output logic [7:0]      p0_level,
   input  wire logic       p1_wr,
   input  wire logic [7:0] p1_wdata,
   output logic [7:0]      p1_level,
   input  wire logic       timer2_ext_pin_drive,
   input  wire logic       serial1_transmit,
   output logic            timer2_ext_pin_level,
   output logic            timer2_trigger_pin,
   output logic            serial1_receive,
   output logic            ext_irq_rise_a,
   output logic            ext_irq_fall_a,
   output logic            ext_irq_rise_b,
   output logic            ext_irq_fall_b,
   output logic            program_store_strobe_n,
   output logic            addr_latch_strobe,
   input  wire logic [7:0] mux_addr_data_low_i,
   output logic [7:0]      mux_addr_data_low_o,
   output logic [7:0]      mux_addr_data_low_oe,
   input  wire logic [7:0] p1_pin_i,
   output logic [7:0]      p1_pin_o,
   output logic [7:0]      p1_pin_oe,
   output logic [7:0]      p1_weak_pu
);

   logic [2:0] phase;
   logic [2:0] next_phase;
   peb_xreq_t  cur;
   peb_xreq_t  next_cur;
   logic [7:0] p0_latch;
   logic [7:0] p0_s1;
   logic       next_strobe;
   logic       next_program_store_strobe_n_n;
   logic [7:0] next_p0_o;
   logic [7:0] next_p0_oe;
   logic [7:0] p1_alt;
   logic [7:0] p1_rise;
   logic [7:0] p1_fall;

   // Machine cycle of four oscillator cycles
   assign next_phase = (phase == PH_LAST) ? 3'h0 : phase + 3'h1;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         phase <= 3'h0;
      end else begin
         phase <= next_phase;
      end
   end

   // Request is taken only at the machine cycle boundary
   assign next_cur = (phase == PH_LAST) ? xreq : cur;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         xreq_slot <= 1'b0;
      end else begin
         xreq_slot <= (next_phase == PH_LAST);
      end
   end

   // Address latch strobe, computed one cycle early so it leaves a flop
   always_comb begin
      next_strobe = 1'b1;
      if (!latch_strobe_disable || next_cur.kind != XK_IDLE) begin
         next_strobe = (next_phase < PH_STROBE_FALL);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         addr_latch_strobe <= 1'b1;
      end else begin
         addr_latch_strobe <= next_strobe;
      end
   end

   assign next_program_store_strobe_n_n = !(next_cur.kind == XK_CODE
                          && next_phase >= PH_PROGRAM_STORE_STROBE_N_FIRST
                          && next_phase <= PH_PROGRAM_STORE_STROBE_N_LAST);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         program_store_strobe_n <= 1'b1;
      end else begin
         program_store_strobe_n <= next_program_store_strobe_n_n;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         p0_latch <= P0_LATCH_RST;
      end else if (p0_wr) begin
         p0_latch <= p0_wdata;
      end
   end

   // Bus mode drives both levels; idle port only sinks
   always_comb begin
      next_p0_o  = 8'h00;
      next_p0_oe = 8'h00;
      case (next_cur.kind)
         XK_IDLE: begin
            next_p0_oe = ~p0_latch;
         end
         XK_CODE, XK_READ: begin
            if (next_phase < PH_STROBE_FALL) begin
               next_p0_o  = next_cur.addr_lo;
               next_p0_oe = 8'hff;
            end
         end
         XK_WRITE: begin
            next_p0_oe = 8'hff;
            if (next_phase < PH_STROBE_FALL) begin
               next_p0_o = next_cur.addr_lo;
            end else begin
               next_p0_o = next_cur.wdata;
            end
         end
         default: begin
            next_p0_o  = 8'h00;
            next_p0_oe = 8'h00;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mux_addr_data_low_o  <= 8'h00;
         mux_addr_data_low_oe <= 8'h00;
      end else begin
         mux_addr_data_low_o  <= next_p0_o;
         mux_addr_data_low_oe <= next_p0_oe;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         p0_s1    <= 8'h00;
         p0_level <= 8'h00;
      end else begin
         p0_s1    <= mux_addr_data_low_i;
         p0_level <= p0_s1;
      end
   end

   // Read data is the synced bus at the end of the cycle, strobe still low
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         xdone  <= 1'b0;
         xrdata <= 8'h00;
      end else begin
         xdone <= (phase == PH_LAST) && (cur.kind != XK_IDLE);
         if (phase == PH_LAST && (cur.kind == XK_CODE || cur.kind == XK_READ)) begin
            xrdata <= p0_level;
         end
      end
   end

   always_comb begin
      p1_alt                = 8'hff;
      p1_alt[BIT_TIMER2_PIN] = timer2_ext_pin_drive;
      p1_alt[BIT_SER1_TX]    = serial1_transmit;
   end

   for (genvar i = 0; i < 8; i++) begin : g_p1
      peb_p1_bit u_bit (
         .clk       (clk),
         .nrst      (nrst),
         .wr        (p1_wr),
         .wdata     (p1_wdata[i]),
         .alt_drive (p1_alt[i]),
         .pin_i     (p1_pin_i[i]),
         .pin_o     (p1_pin_o[i]),
         .pin_oe    (p1_pin_oe[i]),
         .weak_pu   (p1_weak_pu[i]),
         .pin_level (p1_level[i]),
         .rise      (p1_rise[i]),
         .fall      (p1_fall[i])
      );
   end

   // Alternate inputs are already synced flop outputs of the bit cells
   assign timer2_ext_pin_level = p1_level[BIT_TIMER2_PIN];
   assign timer2_trigger_pin   = p1_level[BIT_TIMER2_TRIG];
   assign serial1_receive      = p1_level[BIT_SER1_RX];
   assign ext_irq_rise_a       = p1_rise[BIT_IRQ_RISE_A];
   assign ext_irq_fall_a       = p1_fall[BIT_IRQ_FALL_A];
   assign ext_irq_rise_b       = p1_rise[BIT_IRQ_RISE_B];
   assign ext_irq_fall_b       = p1_fall[BIT_IRQ_FALL_B];

   default clocking dcb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_strobe_fall_phase: assert property ($fell(addr_latch_strobe) |-> phase == 3'h3)
      else $error("address strobe fell at wrong phase");
   a_strobe_rise_phase: assert property ($rose(addr_latch_strobe) |-> phase == 3'h0)
      else $error("address strobe rose at wrong phase");
   a_strobe_off_held: assert property (
      latch_strobe_disable && cur.kind == XK_IDLE && phase == 3'h3
      && $past(latch_strobe_disable) |-> addr_latch_strobe)
      else $error("disabled address strobe pulsed while idle");
   a_strobe_on_access: assert property (
      cur.kind != XK_IDLE && phase == 3'h0 |-> addr_latch_strobe [*3] ##1 !addr_latch_strobe)
      else $error("access cycle without address strobe pulse");
   a_addr_phase_out: assert property (
      cur.kind != XK_IDLE && phase < 3'h3 |->
      mux_addr_data_low_oe == 8'hff && mux_addr_data_low_o == cur.addr_lo)
      else $error("low address not driven while strobe high");
   a_read_bus_float: assert property (
      (cur.kind == XK_CODE || cur.kind == XK_READ) && phase >= 3'h3 |->
      mux_addr_data_low_oe == 8'h00)
      else $error("port 0 driven during read data phase");
   a_program_store_strobe_n_code_pulse: assert property (
      cur.kind == XK_CODE && phase == 3'h4 |->
      !program_store_strobe_n [*3] ##1 program_store_strobe_n)
      else $error("program strobe pulse wrong for code fetch");
   a_program_store_strobe_n_idle_high: assert property (cur.kind != XK_CODE |-> program_store_strobe_n)
      else $error("program strobe low without code fetch");
   a_p0_open_drain: assert property (cur.kind == XK_IDLE |-> mux_addr_data_low_o == 8'h00)
      else $error("port 0 drove high outside bus mode");
   a_done_timing: assert property (
      cur.kind != XK_IDLE && phase == 3'h7 |=>
      xdone && ($past(cur.kind) == XK_WRITE || $past(p0_level) == xrdata))
      else $error("access completion missing");

   c_code_fetch: cover property (cur.kind == XK_CODE && phase == 3'h7);
   c_ext_write: cover property (cur.kind == XK_WRITE && phase == 3'h7);
   c_strobe_off_access: cover property (latch_strobe_disable && !addr_latch_strobe);
   c_irq_seen: cover property (ext_irq_rise_a || ext_irq_fall_b);

endmodule : peb_pins

// ===== peb_xmem.sv
// External code memory and address latch on the multiplexed port 0 bus
`timescale 1ns/1ps
module peb_xmem (
   input  wire logic       clk,
   input  wire logic       strobe,
   input  wire logic       program_store_strobe_n_n,
   input  wire logic [7:0] bus,
   input  wire logic [7:0] dev_oe,
   output logic [7:0]      mem_o,
   output logic            mem_oe,
   output logic [7:0]      addr_q,
   output logic [7:0]      wr_q
);
   // Transparent latch follows the bus while the strobe is high
   always_latch begin
      if (strobe) addr_q <= bus;
   end

   // Chip enable only; the bus falls back to its pull-ups once released
   assign mem_oe = ~program_store_strobe_n_n;
   assign mem_o  = addr_q ^ 8'h3c;

   always_ff @(posedge clk) begin
      if (!strobe && program_store_strobe_n_n && dev_oe == 8'hff) wr_q <= bus;
   end
endmodule : peb_xmem

// ===== peb_pins_tb.sv
// Self-checking bench for the port and external bus pin logic
`timescale 1ns/1ps
module peb_pins_tb
   import peb_pkg::*;
;
   typedef struct packed {
      peb_xreq_t  req;
      logic [7:0] rd;
   } peb_row_t;

   localparam peb_row_t ROWS [5] = '{
      '{'{XK_CODE, 8'h00, 8'h00}, 8'h3c},
      '{'{XK_CODE, 8'hff, 8'h00}, 8'hc3},
      '{'{XK_CODE, 8'ha5, 8'h00}, 8'h99},
      '{'{XK_READ, 8'h5a, 8'h00}, 8'hff},
      '{'{XK_WRITE, 8'ha5, 8'h69}, 8'h69}};

   logic       clk = 1'b0;
   logic       nrst = 1'b0;
   logic       latch_strobe_disable = 1'b0;
   peb_xreq_t  xreq = '{XK_IDLE, 8'h00, 8'h00};
   logic       p0_wr = 1'b0;
   logic [7:0] p0_wdata = 8'hff;
   logic       p1_wr = 1'b0;
   logic [7:0] p1_wdata = 8'hff;
   logic       timer2_ext_pin_drive = 1'b1;
   logic       serial1_transmit = 1'b1;
   logic [7:0] ext_o = 8'hff;
   logic [7:0] ext_oe = 8'h00;
   logic       xreq_slot, xdone, timer2_ext_pin_level, timer2_trigger_pin;
   logic       serial1_receive, ext_irq_rise_a, ext_irq_fall_a, ext_irq_rise_b;
   logic       ext_irq_fall_b, program_store_strobe_n, addr_latch_strobe, mem_oe;
   logic [7:0] xrdata, p0_level, p1_level, mux_addr_data_low_i, mux_addr_data_low_o;
   logic [7:0] mux_addr_data_low_oe, p1_pin_i, p1_pin_o, p1_pin_oe, p1_weak_pu;
   logic [7:0] mem_o, addr_q, wr_q;
   int         error_cnt = 0;
   int         samples_checked = 0;
   int         cyc = 0;

   // Port 0 idles at its external pull-ups; port 1 at its weak pull-ups
   assign mux_addr_data_low_i = (mux_addr_data_low_o & mux_addr_data_low_oe)
      | (~mux_addr_data_low_oe & (mem_oe ? mem_o : 8'hff));
   assign p1_pin_i = (p1_pin_o & p1_pin_oe) | (~p1_pin_oe & ~(ext_oe & ~ext_o));

   peb_pins DUT (.*);

   peb_xmem u_xmem (
      .clk    (clk),
      .strobe (addr_latch_strobe),
      .program_store_strobe_n_n (program_store_strobe_n),
      .bus    (mux_addr_data_low_i),
      .dev_oe (mux_addr_data_low_oe),
      .mem_o  (mem_o),
      .mem_oe (mem_oe),
      .addr_q (addr_q),
      .wr_q   (wr_q)
   );

   always #12.5 clk = ~clk;

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run

   // Cut a hang short well beyond the expected run of about 210 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         error_cnt++;
         complete_run();
      end
   end

   task automatic rst_check;
      check("strobes", 8'({addr_latch_strobe, program_store_strobe_n}), 8'h03);
      check("p0_oe", mux_addr_data_low_oe, 8'h00);
      check("p1_weak", p1_weak_pu, 8'hff);
      check("p1_oe", p1_pin_oe, 8'h00);
   endtask : rst_check

   task automatic idle_lows(output int lo, output int rises);
      logic prev;
      lo = 0;
      rises = 0;
      @(negedge clk);
      prev = addr_latch_strobe;
      repeat (16) begin
         @(negedge clk);
         if (addr_latch_strobe === 1'b0) lo++;
         if (addr_latch_strobe === 1'b1 && prev === 1'b0) rises++;
         prev = addr_latch_strobe;
      end
   endtask : idle_lows

   task automatic xfer(input peb_row_t r);
      int lo;
      int ps;
      lo = 0;
      ps = 0;
      @(posedge clk);
      xreq <= r.req;
      do @(posedge clk); while (xreq_slot !== 1'b1);
      xreq <= '{XK_IDLE, 8'h00, 8'h00};
      for (int n = 0; n < 8; n++) begin
         @(negedge clk);
         if (addr_latch_strobe === 1'b0) lo++;
         if (program_store_strobe_n === 1'b0) ps++;
         if (n == 1) begin
            check("addr", mux_addr_data_low_o, r.req.addr_lo);
            check("addr_oe", mux_addr_data_low_oe, 8'hff);
         end
         if (n == 4) begin
            check("data_oe", mux_addr_data_low_oe, (r.req.kind == XK_WRITE) ? 8'hff : 8'h00);
            if (r.req.kind == XK_WRITE) check("wr_out", mux_addr_data_low_o, r.rd);
            // Latch is transparent again once an idle strobe rises, so look now
            check("latched", addr_q, r.req.addr_lo);
         end
      end
      @(negedge clk);
      check("done", 8'(xdone), 8'h01);
      check("strobe_low", 8'(lo), 8'h05);
      check("program_store_strobe_n_low", 8'(ps), (r.req.kind == XK_CODE) ? 8'h03 : 8'h00);
      if (r.req.kind == XK_WRITE) check("wdata", wr_q, r.rd);
      else check("rdata", xrdata, r.rd);
   endtask : xfer

   task automatic p1_write(input logic [7:0] v);
      @(posedge clk);
      p1_wr <= 1'b1;
      p1_wdata <= v;
      @(posedge clk);
      p1_wr <= 1'b0;
   endtask : p1_write

   initial begin
      int lo;
      int rises;
      int kick;
      logic [3:0] acc;
      repeat (20) @(posedge clk);
      rst_check();
      nrst <= 1'b1;
      idle_lows(lo, rises);
      check("idle_low", 8'(lo), 8'h0a);
      check("idle_rises", 8'(rises), 8'h02);
      $display("test reset and idle strobe done");
      @(posedge clk);
      latch_strobe_disable <= 1'b1;
      repeat (2) @(posedge clk);
      idle_lows(lo, rises);
      check("off_low", 8'(lo), 8'h00);
      foreach (ROWS[i]) xfer(ROWS[i]);
      $display("test external accesses done");
      p1_write(8'hfe);
      repeat (3) @(negedge clk);
      check("p1_pull", 8'({p1_pin_oe[0], p1_pin_o[0]}), 8'h02);
      p1_write(8'hff);
      kick = 0;
      repeat (6) begin
         @(negedge clk);
         if (p1_pin_oe[0] === 1'b1 && p1_pin_o[0] === 1'b1) kick++;
      end
      check("p1_kick", 8'(kick), 8'h02);
      check("p1_weak0", 8'({p1_pin_oe[0], p1_weak_pu[0]}), 8'h01);
      @(posedge clk);
      ext_oe <= 8'h07;
      ext_o <= 8'h00;
      repeat (4) @(negedge clk);
      check("alt_in", 8'({timer2_ext_pin_level, timer2_trigger_pin, serial1_receive}),
            8'h00);
      check("p1_level", p1_level, 8'hf8);
      @(posedge clk);
      ext_oe <= 8'h00;
      timer2_ext_pin_drive <= 1'b0;
      serial1_transmit <= 1'b0;
      repeat (3) @(negedge clk);
      check("alt_out", 8'({p1_pin_oe[3], p1_pin_o[3], p1_pin_oe[0], p1_pin_o[0]}),
            8'h0a);
      @(posedge clk);
      timer2_ext_pin_drive <= 1'b1;
      serial1_transmit <= 1'b1;
      for (int b = 4; b < 8; b++) begin
         for (int ph = 0; ph < 2; ph++) begin
            acc = 4'h0;
            @(posedge clk);
            ext_oe[b] <= (ph == 0);
            ext_o[b] <= 1'b0;
            repeat (6) begin
               @(negedge clk);
               acc |= {ext_irq_fall_b, ext_irq_rise_b, ext_irq_fall_a, ext_irq_rise_a};
            end
            check("irq", 8'(acc), (b % 2 == ph) ? 8'h00 : 8'(4'h1 << (b - 4)));
         end
      end
      $display("test port 1 done");
      @(posedge clk);
      p0_wr <= 1'b1;
      p0_wdata <= 8'h0f;
      @(posedge clk);
      p0_wr <= 1'b0;
      repeat (4) @(negedge clk);
      check("p0_oe", mux_addr_data_low_oe, 8'hf0);
      check("p0_o", mux_addr_data_low_o, 8'h00);
      check("p0_level", p0_level, 8'h0f);
      p1_write(8'h00);
      // Reset again with port 1 and port 0 bits 7..4 pulled low to see it restored
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(negedge clk);
      rst_check();
      $display("test port 0 and mid-run reset done");
      complete_run();
   end
endmodule : peb_pins_tb
